// >>> src/pcc_pkg.sv
// Package with constants and types for the capability-structure register bank
//
// Summary of operation
// - Lower power states one and two unsupported
// - Auxiliary current field reads all ones
// - Device-specific initialization bit reads one
// - Power-management version field reads 011
// - Wake flag set by event, write-one clears
// - Wake enable sticky read/write, gates wake
// - No-soft-reset reads zero, no internal reset
// - Power state field held and read back
// - Data and bridge bytes read zero
// - Interrupt-message identifier reads 05h
// - Interrupt-message next pointer reads 60h
// - Message enable writable, capable field single
// - Control bit seven advertises wide addressing
// - Message data at 08h or 0Ch
// - Masked vector sends no message
// - Held-back vector sets its pending bit
// - Express capability identifier reads 10h
// - Express next pointer reads 00h
// - Endpoint type 0001b, version 1h, no slot
// - Captured scale field encodes four multipliers
// - Captured value field held from capture
// - Role-based error reporting bit reads one
// - Power-management identifier reads 01h
// - Power-management next pointer reads 48h
// - Wake source states read 1_1001b
package pcc_pkg;

	// ****************************************
	// Capability bases and list
	// ****************************************
	localparam logic [7:0] PM_BASE      = 8'h40;
	localparam logic [7:0] MSI_BASE     = 8'h48;
	localparam logic [7:0] PCIE_BASE    = 8'h60;
	localparam logic [7:0] PM_CAP_ID    = 8'h01;
	localparam logic [7:0] MSI_CAP_ID   = 8'h05;
	localparam logic [7:0] PCIE_CAP_ID  = 8'h10;
	localparam logic [7:0] LIST_END     = 8'h00;

	// ****************************************
	// Offsets inside a capability
	// ****************************************
	localparam logic [7:0] OFS_HEAD     = 8'h00;
	localparam logic [7:0] OFS_PM_CSR   = 8'h04;
	localparam logic [7:0] OFS_DEV_CAP  = 8'h04;
	localparam logic [7:0] OFS_MSI_ADLO = 8'h04;
	localparam logic [7:0] OFS_MSI_ADHI = 8'h08;
	localparam logic       MSI_WIDE     = 1'b1;
	localparam logic [7:0] OFS_MSG_INT_DATA = MSI_WIDE ? 8'h0c : 8'h08;
	localparam logic [7:0] OFS_MSI_MASK = MSI_WIDE ? 8'h10 : 8'h0c;
	localparam logic [7:0] OFS_MSI_PEND = MSI_WIDE ? 8'h14 : 8'h10;

	// ****************************************
	// Power-management fields
	// ****************************************
	localparam logic [4:0] WAKE_SOURCES = 5'b1_1001;
	localparam logic [2:0] AUX_CURRENT  = 3'b111;
	localparam logic [2:0] PM_VERSION   = 3'b011;
	localparam logic [15:0] PM_CAPS = {WAKE_SOURCES, 1'b0, 1'b0,
		AUX_CURRENT, 1'b1, 1'b0, 1'b0, PM_VERSION};
	localparam int         FLAG_BIT     = 15;
	localparam int         ENABLE_BIT   = 8;
	localparam logic       NO_SOFT_RST  = 1'b0;
	localparam logic [7:0] PM_BSE_VAL   = 8'h00;
	localparam logic [7:0] PM_DATA_VAL  = 8'h00;
	localparam logic [1:0] PSTATE_RST   = 2'b00;

	typedef enum logic [1:0] {
		PCC_D0, PCC_D1, PCC_D2, PCC_D3
	} pcc_pstate_t;

	// ****************************************
	// Interrupt-message and express fields
	// ****************************************
	localparam logic [2:0]  MSG_CAPABLE = 3'b000;
	localparam logic        PV_MASKING  = 1'b1;
	localparam logic [3:0]  PORT_TYPE   = 4'b0001;
	localparam logic [3:0]  PCIE_VER    = 4'h1;
	localparam logic [15:0] PCIE_CAPS = {2'b00, 5'b00000, 1'b0,
		PORT_TYPE, PCIE_VER};
	localparam logic [2:0]  L1_LATENCY  = 3'b100;
	localparam logic [2:0]  L0S_LATENCY = 3'b100;
	localparam logic [2:0]  MAX_PAYLOAD = 3'b010;
	localparam logic        ROLE_ERR    = 1'b1;

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic        wr;
		logic [7:0]  addr;
		logic [3:0]  be;
		logic [31:0] wdata;
	} pcc_cfg_req_t;

	typedef struct packed {
		logic [1:0] scale;
		logic [7:0] value;
	} pcc_slot_pwr_t;

endpackage

// >>> src/pcc_msi_vec.sv
// Single interrupt-message vector with mask and pending hold-back
`timescale 1ns/1ns
`default_nettype none
module pcc_msi_vec
	import pcc_pkg::*;
(
	input  wire logic mclk_in,
	input  wire logic reset_in,
	input  wire logic ce_in,
	input  wire logic event_in,
	input  wire logic mask_in,
	output var  logic pending_out,
	output var  logic send_out
);

	logic pend_ff;
	logic send_ff;

	assign pending_out = pend_ff;
	assign send_out    = send_ff;

	// ****************************************
	// Hold-back and release
	// ****************************************
	// A held message goes out once the mask drops, and pending clears on the same edge
	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			pend_ff <= 1'b0;
			send_ff <= 1'b0;
		end else if (ce_in) begin
			if (mask_in) begin
				send_ff <= 1'b0;
				if (event_in) begin
					pend_ff <= 1'b1;
				end
			end else begin
				send_ff <= event_in | pend_ff;
				pend_ff <= 1'b0;
			end
		end
	end

endmodule
`default_nettype wire

// >>> src/pcc_cap_regs.sv
// Capability structures: power management, interrupt message, express
`timescale 1ns/1ns
`default_nettype none
module pcc_cap_regs
	import pcc_pkg::*;
(
	input  wire logic          mclk_in,
	input  wire logic          reset_in,
	input  wire logic          aux_reset_in,
	input  wire logic          ce_in,
	input  wire logic          cfg_req_in,
	input  wire pcc_cfg_req_t  cfg_cmd_in,
	output var  logic          cfg_ack_out,
	output var  logic [31:0]   cfg_rdata_out,
	input  wire logic          wake_event_in,
	output var  logic          wake_msg_out,
	output var  pcc_pstate_t   power_state_out,
	input  wire logic          irq_event_in,
	output var  logic          msi_send_out,
	input  wire logic          slot_pwr_valid_in,
	input  wire pcc_slot_pwr_t slot_pwr_in
);

	// ****************************************
	// State
	// ****************************************
	logic          ack_ff;
	logic [31:0]   rdata_ff;
	logic          wake_flag_ff;
	logic          wake_en_ff;
	logic          wake_msg_ff;
	pcc_pstate_t   pstate_ff;
	logic [2:0]    mme_ff;
	logic [31:2]   adlo_ff;
	logic [31:0]   adhi_ff;
	logic [15:0]   mdata_ff;
	logic          mask_ff;
	pcc_slot_pwr_t slot_ff;
	logic          pend;
	logic          send;
	logic [31:0]   nxt_rdata;
	logic          wr_go;
	logic          rd_go;
	logic [7:0]    dw_addr;
	logic [15:0]   pm_csr;
	logic [15:0]   msi_ctrl;
	logic [31:0]   dev_caps;
	logic          flag_clr;

	assign cfg_ack_out     = ack_ff;
	assign cfg_rdata_out   = rdata_ff;
	assign wake_msg_out    = wake_msg_ff;
	assign power_state_out = pstate_ff;
	assign msi_send_out    = send;

	assign dw_addr = {cfg_cmd_in.addr[7:2], 2'b00};
	assign wr_go   = ce_in & cfg_req_in & cfg_cmd_in.wr;
	assign rd_go   = ce_in & cfg_req_in & ~cfg_cmd_in.wr;

	// ****************************************
	// Read-back words
	// ****************************************
	assign pm_csr = {wake_flag_ff, 2'b00, 4'b0000, wake_en_ff,
		4'b0000, NO_SOFT_RST, 1'b0, pstate_ff};

	assign msi_ctrl = {7'b0000000, PV_MASKING, MSI_WIDE, mme_ff,
		MSG_CAPABLE, 1'b1};

	assign dev_caps = {3'b000, 1'b0, slot_ff.scale, slot_ff.value,
		2'b00, ROLE_ERR, 1'b0, 1'b0, 1'b0, L1_LATENCY,
		L0S_LATENCY, 1'b0, 2'b00, MAX_PAYLOAD};

	// Unmapped words and reserved bits return zero
	always_comb begin
		nxt_rdata = 32'h0000_0000;
		case (dw_addr)
			PM_BASE + OFS_HEAD:
				nxt_rdata = {PM_CAPS, MSI_BASE, PM_CAP_ID};
			PM_BASE + OFS_PM_CSR:
				nxt_rdata = {PM_DATA_VAL, PM_BSE_VAL, pm_csr};
			MSI_BASE + OFS_HEAD:
				nxt_rdata = {msi_ctrl, PCIE_BASE, MSI_CAP_ID};
			MSI_BASE + OFS_MSI_ADLO:
				nxt_rdata = {adlo_ff, 2'b00};
			MSI_BASE + OFS_MSI_ADHI:
				nxt_rdata = MSI_WIDE ? adhi_ff : {16'h0000, mdata_ff};
			MSI_BASE + OFS_MSG_INT_DATA:
				nxt_rdata = {16'h0000, mdata_ff};
			MSI_BASE + OFS_MSI_MASK:
				nxt_rdata = {31'h0000_0000, mask_ff};
			MSI_BASE + OFS_MSI_PEND:
				nxt_rdata = {31'h0000_0000, pend};
			PCIE_BASE + OFS_HEAD:
				nxt_rdata = {PCIE_CAPS, LIST_END, PCIE_CAP_ID};
			PCIE_BASE + OFS_DEV_CAP:
				nxt_rdata = dev_caps;
			default:
				nxt_rdata = 32'h0000_0000;
		endcase
	end

	// ****************************************
	// Request answer
	// ****************************************
	// Every request taken while ce_in is high, mapped or not, is answered one cycle later
	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			ack_ff   <= 1'b0;
			rdata_ff <= 32'h0000_0000;
		end else if (ce_in) begin
			ack_ff <= cfg_req_in;
			if (rd_go) begin
				rdata_ff <= nxt_rdata;
			end
		end
	end

	// ****************************************
	// Power-management control/status
	// ****************************************
	assign flag_clr = wr_go && dw_addr == PM_BASE + OFS_PM_CSR &&
		cfg_cmd_in.be[1] && cfg_cmd_in.wdata[FLAG_BIT];

	// Sticky bits live on the auxiliary reset only
	always_ff @(posedge mclk_in) begin
		if (aux_reset_in) begin
			wake_flag_ff <= 1'b0;
			wake_en_ff   <= 1'b0;
		end else if (ce_in) begin
			if (wake_event_in) begin
				wake_flag_ff <= 1'b1;
			end else if (flag_clr) begin
				wake_flag_ff <= 1'b0;
			end
			if (wr_go && dw_addr == PM_BASE + OFS_PM_CSR &&
					cfg_cmd_in.be[1]) begin
				// Cold-state wake support decides if enable exists
				wake_en_ff <= cfg_cmd_in.wdata[ENABLE_BIT] &
					WAKE_SOURCES[4];
			end
		end
	end

	// Lower power states are not supported, so those writes are dropped
	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			pstate_ff <= pcc_pstate_t'(PSTATE_RST);
		end else if (ce_in) begin
			if (wr_go && dw_addr == PM_BASE + OFS_PM_CSR &&
					cfg_cmd_in.be[0]) begin
				unique case (pcc_pstate_t'(cfg_cmd_in.wdata[1:0]))
					PCC_D0: pstate_ff <= PCC_D0;
					PCC_D3: pstate_ff <= PCC_D3;
					PCC_D1: pstate_ff <= pstate_ff;
					PCC_D2: pstate_ff <= pstate_ff;
				endcase
			end
		end
	end

	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			wake_msg_ff <= 1'b0;
		end else if (ce_in) begin
			wake_msg_ff <= wake_event_in & wake_en_ff;
		end
	end

	// ****************************************
	// Interrupt-message registers
	// ****************************************
	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			mme_ff   <= 3'b000;
			adlo_ff  <= 30'h0000_0000;
			adhi_ff  <= 32'h0000_0000;
			mdata_ff <= 16'h0000;
			mask_ff  <= 1'b0;
		end else if (wr_go) begin
			if (dw_addr == MSI_BASE + OFS_HEAD && cfg_cmd_in.be[2]) begin
				mme_ff <= cfg_cmd_in.wdata[22:20];
			end
			if (dw_addr == MSI_BASE + OFS_MSI_ADLO) begin
				if (cfg_cmd_in.be[0]) adlo_ff[7:2] <= cfg_cmd_in.wdata[7:2];
				if (cfg_cmd_in.be[1]) adlo_ff[15:8] <= cfg_cmd_in.wdata[15:8];
				if (cfg_cmd_in.be[2]) adlo_ff[23:16] <= cfg_cmd_in.wdata[23:16];
				if (cfg_cmd_in.be[3]) adlo_ff[31:24] <= cfg_cmd_in.wdata[31:24];
			end
			if (MSI_WIDE && dw_addr == MSI_BASE + OFS_MSI_ADHI) begin
				for (int i = 0; i < 4; i++) begin
					if (cfg_cmd_in.be[i]) begin
						adhi_ff[i*8 +: 8] <= cfg_cmd_in.wdata[i*8 +: 8];
					end
				end
			end
			if (dw_addr == MSI_BASE + OFS_MSG_INT_DATA) begin
				if (cfg_cmd_in.be[0]) mdata_ff[7:0] <= cfg_cmd_in.wdata[7:0];
				if (cfg_cmd_in.be[1]) mdata_ff[15:8] <= cfg_cmd_in.wdata[15:8];
			end
			if (dw_addr == MSI_BASE + OFS_MSI_MASK && cfg_cmd_in.be[0]) begin
				mask_ff <= cfg_cmd_in.wdata[0];
			end
		end
	end

	pcc_msi_vec u_vec (
		.mclk_in     (mclk_in),
		.reset_in    (reset_in),
		.ce_in       (ce_in),
		.event_in    (irq_event_in),
		.mask_in     (mask_ff),
		.pending_out (pend),
		.send_out    (send)
	);

	// ****************************************
	// Captured slot power
	// ****************************************
	// Filled by the slot-power message, not by configuration writes
	always_ff @(posedge mclk_in) begin
		if (reset_in) begin
			slot_ff <= '0;
		end else if (ce_in && slot_pwr_valid_in) begin
			slot_ff <= slot_pwr_in;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (reset_in || aux_reset_in);

	a_pm_head_read: assert property (
		rd_go && dw_addr == PM_BASE |=>
		cfg_rdata_out == {16'hc9e3, 8'h48, 8'h01})
		else $error("power head word wrong");

	a_wake_flag_set: assert property (
		ce_in && wake_event_in |=> wake_msg_out == $past(wake_en_ff) ##0
		wake_flag_ff)
		else $error("wake flag not set");

	a_flag_zero_keep: assert property (
		wake_flag_ff && ce_in && !wake_event_in && !flag_clr |=>
		wake_flag_ff)
		else $error("wake flag lost");

	a_enable_stable: assert property (
		!(wr_go && dw_addr == PM_BASE + OFS_PM_CSR) |=>
		$stable(wake_en_ff))
		else $error("wake enable changed");

	a_pstate_readback: assert property (
		rd_go && dw_addr == PM_BASE + OFS_PM_CSR |=>
		cfg_rdata_out[31:16] == 16'h0000 &&
		cfg_rdata_out[7:0] == {6'b000000, $past(pstate_ff)})
		else $error("power state read wrong");

	a_pstate_no_lower: assert property (
		pstate_ff != PCC_D1 && pstate_ff != PCC_D2)
		else $error("unsupported power state held");

	a_msi_head_read: assert property (
		rd_go && dw_addr == MSI_BASE |=>
		cfg_rdata_out[15:0] == 16'h6005 && cfg_rdata_out[16])
		else $error("message head word wrong");

	a_mask_blocks: assert property (
		ce_in && mask_ff |=> !msi_send_out)
		else $error("masked message sent");

	a_pending_release: assert property (
		ce_in && pend && !mask_ff |=>
		msi_send_out && !pend)
		else $error("held message not released");

	a_pcie_head_read: assert property (
		rd_go && dw_addr == PCIE_BASE |=>
		cfg_rdata_out == 32'h0011_0010)
		else $error("express head word wrong");

	a_devcap_read: assert property (
		rd_go && dw_addr == PCIE_BASE + OFS_DEV_CAP |=>
		cfg_rdata_out[15] && cfg_rdata_out[27:18] == $past(slot_ff))
		else $error("device capabilities wrong");

	a_unmapped_zero: assert property (
		rd_go && (dw_addr < PM_BASE ||
		dw_addr > PCIE_BASE + OFS_DEV_CAP) |=>
		cfg_ack_out && cfg_rdata_out == 32'h0000_0000)
		else $error("unmapped read not zero");

	// ****************************************
	// Register-write, read-back and event checks
	// ****************************************
	a_flag_w1c: assert property (
		flag_clr && !wake_event_in |=> !wake_flag_ff)
		else $error("wake flag not cleared");

	a_enable_write: assert property (
		wr_go && dw_addr == PM_BASE + OFS_PM_CSR && cfg_cmd_in.be[1] |=>
		wake_en_ff == $past(cfg_cmd_in.wdata[ENABLE_BIT]))
		else $error("wake enable not written");

	a_wake_msg_gate: assert property (
		ce_in && !wake_en_ff |=> !wake_msg_out)
		else $error("wake message while disabled");

	a_csr_reserved: assert property (
		rd_go && dw_addr == PM_BASE + OFS_PM_CSR |=>
		cfg_rdata_out[14:9] == 6'b000000 &&
		cfg_rdata_out[7:2] == 6'b000000)
		else $error("control reserved bits set");

	a_pstate_take: assert property (
		wr_go && dw_addr == PM_BASE + OFS_PM_CSR && cfg_cmd_in.be[0] &&
		(cfg_cmd_in.wdata[1:0] == 2'b00 ||
		cfg_cmd_in.wdata[1:0] == 2'b11) |=>
		pstate_ff == $past(cfg_cmd_in.wdata[1:0]))
		else $error("power state not taken");

	a_mme_write: assert property (
		wr_go && dw_addr == MSI_BASE && cfg_cmd_in.be[2] |=>
		mme_ff == $past(cfg_cmd_in.wdata[22:20]))
		else $error("message enable not written");

	a_msg_data_read: assert property (
		rd_go && dw_addr == MSI_BASE + OFS_MSG_INT_DATA |=>
		cfg_rdata_out == {16'h0000, $past(mdata_ff)})
		else $error("message data read wrong");

	a_pending_set: assert property (
		ce_in && mask_ff && irq_event_in |=> pend)
		else $error("held message not pending");

	a_slot_capture: assert property (
		ce_in && slot_pwr_valid_in |=> slot_ff == $past(slot_pwr_in))
		else $error("slot power not captured");

	c_wake_clear: cover property (wake_flag_ff ##1 !wake_flag_ff);
	c_flag_race: cover property (ce_in && wake_event_in && flag_clr);
	c_msi_held: cover property (pend ##[1:8] msi_send_out);
	c_enter_d3: cover property (pstate_ff == PCC_D3);
	c_msi_direct: cover property (!mask_ff && irq_event_in ##1 send);

endmodule
`default_nettype wire

// >>> test/pcc_root_model.sv
// Root-complex model issuing configuration requests
`timescale 1ns/1ns
`default_nettype none
module pcc_root_model
	import pcc_pkg::*;
(
	input  wire logic         mclk_in,
	input  wire logic         cfg_ack_in,
	input  wire logic [31:0]  cfg_rdata_in,
	output var  logic         cfg_req_out,
	output var  pcc_cfg_req_t cfg_cmd_out
);
	initial begin
		cfg_req_out = 1'b0;
		cfg_cmd_out = '0;
	end

	// ****************************************
	// One dword request, answer awaited
	// ****************************************
	// Command scrambled once taken so stale fields are never reused
	task automatic access(input logic wr, input logic [7:0] addr,
		input logic [3:0] be, input logic [31:0] wdata,
		output logic [31:0] rdata, output logic ok);
		int n;
		@(negedge mclk_in);
		cfg_req_out = 1'b1;
		cfg_cmd_out = '{wr: wr, addr: addr, be: be, wdata: wdata};
		@(negedge mclk_in);
		cfg_req_out = 1'b0;
		cfg_cmd_out = ~cfg_cmd_out;
		ok = 1'b0;
		rdata = '0;
		for (n = 0; n < 4 && !ok; n++) begin
			@(posedge mclk_in);
			if (cfg_ack_in === 1'b1) begin
				ok = 1'b1;
				rdata = cfg_rdata_in;
			end
		end
	endtask
endmodule
`default_nettype wire

// >>> test/pcc_cap_regs_test.sv
// Self-checking bench for the capability register bank
`timescale 1ns/1ns
`default_nettype none
module pcc_cap_regs_test
	import pcc_pkg::*;
;
	logic          mclk, reset, aux_reset, ce, cfg_req;
	logic          wake_ev, irq_ev, sp_valid, ack, wake_msg, msi_send;
	logic          ok;
	pcc_cfg_req_t  cmd;
	pcc_slot_pwr_t sp;
	pcc_pstate_t   pstate;
	logic [31:0]   rdata, rd;
	logic [2:0]    mme;
	logic [15:0]   dpat;
	logic [1:0]    exp_ps;
	int            fails, check_count, wake_cnt, msi_cnt, n0;
	int            seq[4] = '{3, 1, 2, 0};

	pcc_cap_regs u_dut (.mclk_in(mclk), .reset_in(reset),
		.aux_reset_in(aux_reset), .ce_in(ce), .cfg_req_in(cfg_req),
		.cfg_cmd_in(cmd), .cfg_ack_out(ack), .cfg_rdata_out(rdata),
		.wake_event_in(wake_ev), .wake_msg_out(wake_msg),
		.power_state_out(pstate), .irq_event_in(irq_ev),
		.msi_send_out(msi_send), .slot_pwr_valid_in(sp_valid),
		.slot_pwr_in(sp));
	pcc_root_model u_root (.mclk_in(mclk), .cfg_ack_in(ack),
		.cfg_rdata_in(rdata), .cfg_req_out(cfg_req), .cfg_cmd_out(cmd));

	always #25 mclk = ~mclk;
	always @(posedge mclk) begin
		if (wake_msg === 1'b1) wake_cnt++;
		if (msi_send === 1'b1) msi_cnt++;
	end

	// ****************************************
	// Expectations and helpers
	// ****************************************
	function automatic logic [31:0] pm_head();
		return {5'b1_1001, 2'b00, 3'b111, 3'b100, 3'b011, 16'h4801};
	endfunction
	function automatic logic [31:0] msi_head(input logic [2:0] m);
		return {7'h00, 2'b11, m, 4'b0001, 16'h6005};
	endfunction

	task check(input logic [31:0] seen, input logic [31:0] exp,
		input string what);
		check_count++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: %s got %h exp %h", $time, what,
				seen, exp);
		end
	endtask
	task rd_only(input logic [7:0] a);
		u_root.access(1'b0, a, 4'hf, 32'h0000_0000, rd, ok);
		check(32'(ok), 32'h0000_0001, "ack");
	endtask
	task rd_chk(input logic [7:0] a, input logic [31:0] exp, input string w);
		rd_only(a);
		check(rd, exp, w);
	endtask
	task wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
		u_root.access(1'b1, a, be, d, rd, ok);
		check(32'(ok), 32'h0000_0001, "ack");
	endtask
	task pulse(input int which);
		@(negedge mclk);
		wake_ev = (which == 0);
		irq_ev = (which == 1);
		sp_valid = (which == 2);
		@(negedge mclk);
		wake_ev = 1'b0;
		irq_ev = 1'b0;
		sp_valid = 1'b0;
		repeat (2) @(negedge mclk);
	endtask
	task tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// ****************************************
	// Watchdog and main sequence
	// ****************************************
	initial begin
		repeat (5000) @(posedge mclk);
		fails++;
		tally_and_finish;
	end

	initial begin
		{mclk, ce, reset, aux_reset} = 4'b1111;
		{wake_ev, irq_ev, sp_valid} = 3'b000;
		sp = '0;
		void'($urandom(8388));
		repeat (10) @(negedge mclk);
		{reset, aux_reset} = 2'b00;
		check(32'(pstate), 32'h0000_0000, "reset state");
		rd_chk(8'h40, pm_head(), "pm head");
		rd_chk(8'h48, msi_head(3'b000), "msi head");
		rd_chk(8'h60, 32'h0011_0010, "pcie head");
		rd_chk(8'h44, 32'h0000_0000, "pm csr");
		rd_chk(8'h80, 32'h0000_0000, "unmapped");
		wr(8'h40, 4'hf, 32'hffff_ffff);
		wr(8'h60, 4'hf, 32'hffff_ffff);
		wr(8'h80, 4'hf, 32'hffff_ffff);
		rd_chk(8'h40, pm_head(), "pm head ro");
		rd_chk(8'h60, 32'h0011_0010, "pcie head ro");
		// Wake: flag without enable, zero write keeps, one write clears
		pulse(0);
		check(32'(wake_cnt), 32'h0000_0000, "wake blocked");
		rd_chk(8'h44, 32'h0000_8000, "flag set");
		wr(8'h44, 4'h2, 32'h0000_0000);
		rd_chk(8'h44, 32'h0000_8000, "flag kept");
		wr(8'h44, 4'h2, 32'h0000_8100);
		rd_chk(8'h44, 32'h0000_0100, "flag clr");
		pulse(0);
		check(32'(wake_cnt), 32'h0000_0001, "wake sent");
		wr(8'h44, 4'h2, 32'h0000_8100);
		// Enable survives the ordinary reset
		@(negedge mclk);
		reset = 1'b1;
		repeat (2) @(negedge mclk);
		reset = 1'b0;
		rd_chk(8'h44, 32'h0000_0100, "sticky");
		// Power states, read-only no-soft-reset bit three written high
		exp_ps = 2'b00;
		foreach (seq[i]) begin
			wr(8'h44, 4'h1, 32'h0000_0008 | seq[i]);
			if (seq[i] == 0 || seq[i] == 3) exp_ps = seq[i][1:0];
			check(32'(pstate), 32'(exp_ps), "state out");
			rd_chk(8'h44, {23'h0, 1'b1, 6'h00, exp_ps}, "state rd");
		end
		// Interrupt message control, data and masking
		mme = 3'($urandom);
		wr(8'h48, 4'h4, {9'h000, mme, 3'b111, 17'h0_0000});
		rd_chk(8'h48, msi_head(mme), "msi ctrl");
		repeat (4) begin
			dpat = 16'($urandom);
			wr(8'h54, 4'hf, {16'hffff, dpat});
			rd_chk(8'h54, {16'h0000, dpat}, "msg data");
		end
		n0 = msi_cnt;
		pulse(1);
		check(32'(msi_cnt - n0), 32'h0000_0001, "unmasked");
		wr(8'h58, 4'h1, 32'h0000_0001);
		pulse(1);
		check(32'(msi_cnt - n0), 32'h0000_0001, "masked");
		rd_chk(8'h5c, 32'h0000_0001, "pending");
		wr(8'h5c, 4'hf, 32'h0000_0000);
		rd_chk(8'h5c, 32'h0000_0001, "pending ro");
		wr(8'h58, 4'h1, 32'h0000_0000);
		repeat (2) @(negedge mclk);
		check(32'(msi_cnt - n0), 32'h0000_0002, "released");
		rd_chk(8'h5c, 32'h0000_0000, "pending clr");
		// Captured slot power, every scale code
		for (int s = 0; s < 4; s++) begin
			@(negedge mclk);
			sp = '{scale: s[1:0], value: 8'($urandom)};
			pulse(2);
			wr(8'h64, 4'hf, 32'hffff_ffff);
			rd_only(8'h64);
			check(32'(rd[27:26]), 32'(sp.scale), "scale");
			check(32'(rd[25:18]), 32'(sp.value), "value");
			check({rd[31:29], rd[17:0]}, 32'h0000_8902, "dev caps");
		end
		tally_and_finish;
	end
endmodule
`default_nettype wire
